// *** clk_mult_regs.svh ***
// register offsets, field positions, reset values and timing counts for the
// sample clock multiplier control block; included by its bare name.
//
// Notes on behaviour
// [R1] enable low: multiplier powered down, sample clock pins drive sampling; during reset mult_power_down is 0
// [R2] enable high: sampling clock from reference through the multiplier
// [R3] oscillator = ref x loop x osc ratio; sample clock = ref x loop ratio
// [R4] software keeps oscillator frequency between 1.0 GHz and 2.1 GHz
// [R5] oscillator range split into 64 overlapping bands chosen by an index
// [R6] software programs loop bandwidth 111 and charge pump 00111, value 0xE7
// [R7] software leaves the cross point control enable bit at zero; the test sets it by writing 0x10 to offset 0x15, then writes 0x00
// [R8] writing 0xC0 then 0x80 to control starts automatic band search
// [R9] manual bit high: manual band field sets the oscillator band directly
// [R10] auto order: ratios, loop tuning, manual, enable, then clear mode bit
// [R11] manual sequence: ratios, loop tuning, band, manual, then enable
// [R12] duty and level correction enabled by bits in two receiver registers
// [R13] phase detector supplies a lock status usable as an event source
// [R14] lock low during band search; reported only after band is applied; lock_status can still be high in the first search cycle
`ifndef CLK_MULT_REGS_SVH
`define CLK_MULT_REGS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define OFS_DUTY_CORR      8'h10
`define OFS_LEVEL_CORR     8'h11
`define OFS_MULT_CTRL      8'h12
`define OFS_LOOP_TUNING    8'h14
`define OFS_CROSS_POINT    8'h15
`define OFS_DIVIDE_RATIOS  8'h16
`define OFS_MULT_STATUS    8'h17

// ----------------------------------------------------------------------
// reset values and command bytes
// ----------------------------------------------------------------------
`define RST_ZERO           8'h00
`define RST_LOOP_TUNING    8'hE7
`define RST_DIVIDE_RATIOS  8'h21
`define CMD_AUTO_ARM       8'hC0
`define CMD_AUTO_GO        8'h80

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BIT_CORR_EN        0
`define BIT_XPOINT_EN      4
`define BAND_LAST          6'h3F
`define BAND_FIRST         6'h00

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS      20
`define BAND_SETTLE_NS     1000
`define BAND_SETTLE_CYC    ((`BAND_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** clk_mult_pkg.sv ***
// types shared by the sample clock multiplier control block.
// assumes the constants header is compiled alongside.
package clk_mult_pkg;

	// multiplier control register layout
	typedef struct packed {
		logic       enable;
		logic       manual;
		logic [5:0] band;
	} mult_ctrl_t;

	// divider ratio register layout
	typedef struct packed {
		logic [2:0] osc_divide_ratio;
		logic [4:0] loop_divide_ratio;
	} divide_ratios_t;

	// clock path controls handed to the analog side
	typedef struct packed {
		logic       use_multiplier;
		logic       mult_power_down;
		logic [5:0] osc_band;
		logic [4:0] sample_ratio;
		logic [7:0] vco_ratio;
	} clock_path_t;

	typedef enum logic [1:0] {
		SRCH_IDLE   = 2'b00,
		SRCH_SETTLE = 2'b01,
		SRCH_CHECK  = 2'b10
	} search_state_t;

endpackage : clk_mult_pkg

// *** dac_clock_multiplier_control.sv ***
// register control of the converter sample clock source and multiplier.
// assumes the serial port decoder delivers one-cycle register strobes
// synchronous to ref_clk, and analog status inputs already synchronised.
`timescale 1ns/1ps
`include "clk_mult_regs.svh"

module dac_clock_multiplier_control
	import clk_mult_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        reset,
	// register strobes from the serial port
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	// analog status
	input  wire logic        band_fit,
	input  wire logic        phase_lock_raw,
	// clock path controls
	output clock_path_t      clock_path,
	output logic      [7:0]  loop_tuning,
	output logic             cross_point_en,
	output logic             duty_corr_en,
	output logic             level_corr_en,
	output logic             lock_status
);

	mult_ctrl_t     ctrl_ff, nxt_ctrl;
	divide_ratios_t div_ff, nxt_div;
	logic [7:0]     tuning_ff, nxt_tuning;
	logic [7:0]     xpoint_ff, nxt_xpoint;
	logic [7:0]     duty_ff, nxt_duty;
	logic [7:0]     level_ff, nxt_level;
	logic           armed_ff, nxt_armed;
	logic [7:0]     rdata_ff, nxt_rdata;
	search_state_t  state_ff, nxt_state;
	logic [5:0]     idx_ff, nxt_idx;
	logic [5:0]     auto_band_ff, nxt_auto_band;
	logic           auto_done_ff, nxt_auto_done;
	logic [7:0]     settle_ff, nxt_settle;
	clock_path_t    path_ff, nxt_path;
	logic           lock_ff, nxt_lock;

	function automatic logic hit(input logic [7:0] ofs);
		hit = reg_wr && (reg_addr == ofs);
	endfunction : hit

	// ----------------------------------------------------------------------
	// register file, search and clock path
	// ----------------------------------------------------------------------
	always_comb begin
		nxt_ctrl      = ctrl_ff;
		nxt_div       = div_ff;
		nxt_tuning    = tuning_ff;
		nxt_xpoint    = xpoint_ff;
		nxt_duty      = duty_ff;
		nxt_level     = level_ff;
		nxt_armed     = armed_ff;
		nxt_state     = state_ff;
		nxt_idx       = idx_ff;
		nxt_auto_band = auto_band_ff;
		nxt_auto_done = auto_done_ff;
		nxt_settle    = settle_ff;
		nxt_rdata     = rdata_ff;

		// walk the bands until the oscillator fits, see [R5]
		unique case (state_ff)
			SRCH_IDLE: begin
			end
			SRCH_SETTLE: begin
				if (settle_ff != 8'h00)
					nxt_settle = settle_ff - 8'h01;
				else
					nxt_state = SRCH_CHECK;
			end
			SRCH_CHECK: begin
				// no fitting band: keep the top one rather than hang
				if (band_fit || idx_ff == `BAND_LAST) begin
					nxt_auto_band = idx_ff;
					nxt_auto_done = 1'b1;
					nxt_state     = SRCH_IDLE;
				end else begin
					nxt_idx    = idx_ff + 6'h01;
					nxt_settle = 8'(`BAND_SETTLE_CYC);
					nxt_state  = SRCH_SETTLE;
				end
			end
		endcase

		// register writes come after the search step so that a control
		// write in the same cycle aborts or restarts it cleanly
		if (hit(`OFS_DUTY_CORR)) nxt_duty = reg_wdata; // see [R12]
		if (hit(`OFS_LEVEL_CORR)) nxt_level = reg_wdata; // see [R12]
		if (hit(`OFS_LOOP_TUNING)) nxt_tuning = reg_wdata;
		if (hit(`OFS_CROSS_POINT)) nxt_xpoint = reg_wdata;
		if (hit(`OFS_DIVIDE_RATIOS)) nxt_div = reg_wdata;
		if (hit(`OFS_MULT_CTRL)) begin
			nxt_ctrl  = reg_wdata;
			nxt_armed = (reg_wdata == `CMD_AUTO_ARM);
			// any rewrite of control clears the search-done flag; the found band stays in auto_band_ff, shown on osc_band while idle with manual low
			nxt_auto_done = 1'b0;
			nxt_state     = SRCH_IDLE;
			if (armed_ff && reg_wdata == `CMD_AUTO_GO) begin // see [R8]
				nxt_state  = SRCH_SETTLE;
				nxt_idx    = `BAND_FIRST;
				nxt_settle = 8'(`BAND_SETTLE_CYC);
			end
		end else if (hit(`OFS_DUTY_CORR) || hit(`OFS_LEVEL_CORR)
			|| hit(`OFS_LOOP_TUNING) || hit(`OFS_CROSS_POINT)
			|| hit(`OFS_DIVIDE_RATIOS)) begin
			nxt_armed = 1'b0;
		end

		unique case (reg_addr)
			`OFS_DUTY_CORR:     nxt_rdata = duty_ff;
			`OFS_LEVEL_CORR:    nxt_rdata = level_ff;
			`OFS_MULT_CTRL:     nxt_rdata = ctrl_ff;
			`OFS_LOOP_TUNING:   nxt_rdata = tuning_ff;
			`OFS_CROSS_POINT:   nxt_rdata = xpoint_ff;
			`OFS_DIVIDE_RATIOS: nxt_rdata = div_ff;
			`OFS_MULT_STATUS:
				nxt_rdata = {lock_ff, state_ff != SRCH_IDLE,
					path_ff.osc_band};
			default:            nxt_rdata = `RST_ZERO;
		endcase
		if (!reg_rd) nxt_rdata = rdata_ff;
	end

	always_comb begin
		nxt_path.use_multiplier  = ctrl_ff.enable; // see [R1] see [R2]
		nxt_path.mult_power_down = !ctrl_ff.enable; // see [R1]
		if (ctrl_ff.manual)
			nxt_path.osc_band = ctrl_ff.band; // see [R9]
		else if (state_ff != SRCH_IDLE)
			nxt_path.osc_band = idx_ff;
		else
			nxt_path.osc_band = auto_band_ff;
		nxt_path.sample_ratio = div_ff.loop_divide_ratio; // see [R3]
		// widen first so the product keeps all of its bits
		nxt_path.vco_ratio = 8'(div_ff.loop_divide_ratio)
			* 8'(div_ff.osc_divide_ratio); // see [R3]
		// lock hidden until a band is really in place, see [R14]
		nxt_lock = ctrl_ff.enable && phase_lock_raw // see [R13]
			&& state_ff == SRCH_IDLE
			&& (ctrl_ff.manual || auto_done_ff);
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ctrl_ff      <= `RST_ZERO;
			div_ff       <= `RST_DIVIDE_RATIOS;
			tuning_ff    <= `RST_LOOP_TUNING;
			xpoint_ff    <= `RST_ZERO;
			duty_ff      <= `RST_ZERO;
			level_ff     <= `RST_ZERO;
			armed_ff     <= 1'b0;
			state_ff     <= SRCH_IDLE;
			idx_ff       <= `BAND_FIRST;
			auto_band_ff <= `BAND_FIRST;
			auto_done_ff <= 1'b0;
			settle_ff    <= `RST_ZERO;
			rdata_ff     <= `RST_ZERO;
			path_ff      <= '0;
			lock_ff      <= 1'b0;
		end else begin
			ctrl_ff      <= nxt_ctrl;
			div_ff       <= nxt_div;
			tuning_ff    <= nxt_tuning;
			xpoint_ff    <= nxt_xpoint;
			duty_ff      <= nxt_duty;
			level_ff     <= nxt_level;
			armed_ff     <= nxt_armed;
			state_ff     <= nxt_state;
			idx_ff       <= nxt_idx;
			auto_band_ff <= nxt_auto_band;
			auto_done_ff <= nxt_auto_done;
			settle_ff    <= nxt_settle;
			rdata_ff     <= nxt_rdata;
			path_ff      <= nxt_path;
			lock_ff      <= nxt_lock;
		end
	end

	assign reg_rdata      = rdata_ff;
	assign clock_path     = path_ff;
	assign loop_tuning    = tuning_ff;
	assign cross_point_en = xpoint_ff[`BIT_XPOINT_EN];
	assign duty_corr_en   = duty_ff[`BIT_CORR_EN];
	assign level_corr_en  = level_ff[`BIT_CORR_EN];
	assign lock_status    = lock_ff;

endmodule : dac_clock_multiplier_control

// *** clk_mult_props.sv ***
// assertions on the clock multiplier control block ports
// assumes one clock domain, ref_clk, with async active-high reset
`timescale 1ns/1ps
module clk_mult_props
	import clk_mult_pkg::*;
(
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        reset,
	// register strobes
	input wire logic        reg_wr,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	// status and controls
	input wire logic        phase_lock_raw,
	input wire clock_path_t clock_path,
	input wire logic        duty_corr_en,
	input wire logic        lock_status
);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	logic wr12;
	logic wr10;
	logic wr16;
	assign wr12 = reg_wr && reg_addr == 8'h12;
	assign wr10 = reg_wr && reg_addr == 8'h10;
	assign wr16 = reg_wr && reg_addr == 8'h16;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	sequence s_arm_go;
		wr12 && reg_wdata == 8'hC0 ##1 wr12 && reg_wdata == 8'h80;
	endsequence
	chk_bypass_pdown: assert property (!$past(reset) &&
		!clock_path.use_multiplier |-> clock_path.mult_power_down)
		else $error("power down not set in bypass");
	chk_mult_follows: assert property (wr12 |-> ##2
		clock_path.use_multiplier == $past(reg_wdata[7], 2))
		else $error("multiplier select wrong");
	chk_manual_band: assert property (wr12 && reg_wdata[6] |-> ##2
		clock_path.osc_band == $past(reg_wdata[5:0], 2))
		else $error("manual band wrong");
	chk_ratio_prod: assert property (wr16 |-> ##2
		clock_path.vco_ratio == $past(reg_wdata[4:0], 2) *
		$past(reg_wdata[7:5], 2))
		else $error("oscillator ratio wrong");
	chk_duty_enable: assert property (wr10 ##1 !wr10 |=>
		duty_corr_en == $past(reg_wdata[0], 2))
		else $error("duty correction enable wrong");
	chk_lock_cause: assert property (lock_status |->
		$past(phase_lock_raw) && clock_path.use_multiplier)
		else $error("lock without cause");
	chk_search_quiet: assert property (wr12 && !reg_wdata[6] |->
		##2 !lock_status [*8])
		else $error("lock during search");
	chk_search_start: assert property (s_arm_go |-> ##2
		clock_path.osc_band == 6'h00 ##[40:60] clock_path.osc_band == 6'h01)
		else $error("band search did not step");
endmodule : clk_mult_props

bind dac_clock_multiplier_control clk_mult_props i_clk_mult_props (
	.ref_clk, .reset, .reg_wr, .reg_addr, .reg_wdata,
	.phase_lock_raw, .clock_path, .duty_corr_en, .lock_status
);

// *** clk_source_model.sv ***
// external reference source and analog loop seen from the control block
// assumes clock_path from the device under test
`timescale 1ns/1ps
module clk_source_model
	import clk_mult_pkg::*;
#(
	parameter logic [5:0] FIT_BAND = 6'h05
)(
	// clock
	input  wire logic        ref_clk,
	// controls from the device
	input  wire clock_path_t clock_path,
	// analog status back
	output logic             band_fit,
	output logic             phase_lock_raw
);
	// ------------------------------------------------------------
	// loop response
	// ------------------------------------------------------------
	// low bands miss the range, so a search must pass several bands
	always_ff @(posedge ref_clk) begin
		band_fit       <= clock_path.use_multiplier
			&& clock_path.osc_band >= FIT_BAND;
		phase_lock_raw <= clock_path.use_multiplier
			&& clock_path.osc_band >= FIT_BAND;
	end
endmodule : clk_source_model

// *** dac_clock_multiplier_control_test.sv ***
// register-level test of the clock multiplier control block
// assumes the partner model and the bound checker
`timescale 1ns/1ps
module dac_clock_multiplier_control_test
	import clk_mult_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic [7:0]  reg_rdata, loop_tuning;
	logic        band_fit, phase_lock_raw, cross_point_en;
	logic        duty_corr_en, level_corr_en, lock_status;
	clock_path_t clock_path;
	int          miscompares = 0;
	int          cmp_count = 0;
	int          cycles = 0;
	always #10 ref_clk = ~ref_clk;
	dac_clock_multiplier_control i_dac_clock_multiplier_control (
		.ref_clk, .reset, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
		.reg_rdata, .band_fit, .phase_lock_raw, .clock_path, .loop_tuning,
		.cross_point_en, .duty_corr_en, .level_corr_en, .lock_status
	);
	clk_source_model i_clk_source_model (
		.ref_clk, .clock_path, .band_fit, .phase_lock_raw
	);
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task close_out;
		$display("miscompares %0d of %0d", miscompares, cmp_count);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out
	task chk(input logic [20:0] got, input logic [20:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	// strobe left high so writes can run back to back
	task wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge ref_clk);
	endtask : wr
	task idle(input int n);
		reg_wr = 1'b0;
		repeat (n) @(negedge ref_clk);
	endtask : idle
	task rd(input logic [7:0] a, input logic [7:0] exp);
		reg_wr = 1'b0;
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge ref_clk);
		reg_rd = 1'b0;
		@(negedge ref_clk);
		chk(21'(reg_rdata), 21'(exp));
	endtask : rd
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			miscompares++;
			close_out();
		end
	end
	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(negedge ref_clk);
		reset = 1'b0;
		@(negedge ref_clk);
		rd(8'h14, 8'hE7);
		rd(8'h12, 8'h00);
		rd(8'h13, 8'h00);
		chk(21'(clock_path.mult_power_down), 21'h1);
		wr(8'h14, 8'h3C);
		idle(1);
		chk(21'(loop_tuning), 21'h3C);
		wr(8'h16, 8'h44);
		wr(8'h14, 8'hE7);
		wr(8'h12, 8'h07);
		wr(8'h12, 8'h47);
		wr(8'h12, 8'hC7);
		wr(8'h10, 8'h01);
		wr(8'h11, 8'h01);
		wr(8'h15, 8'h10);
		idle(6);
		chk(clock_path,
			{1'b1, 1'b0, 6'h07, 5'h04, 8'h08});
		chk(21'({duty_corr_en, level_corr_en, cross_point_en, lock_status}),
			21'hF);
		wr(8'h15, 8'h00);
		wr(8'h12, 8'h40);
		wr(8'h12, 8'hC0);
		wr(8'h12, 8'h80);
		idle(3);
		chk(21'(lock_status), 21'h0);
		for (int i = 0; i < 600 && lock_status !== 1'b1; i++) begin
			@(negedge ref_clk);
		end
		chk(21'(clock_path.osc_band), 21'h05);
		rd(8'h17, 8'h85);
		// second search, aborted while it steps through band one
		wr(8'h12, 8'hC0);
		wr(8'h12, 8'h80);
		idle(60);
		rd(8'h17, 8'h41);
		wr(8'h12, 8'h00);
		idle(4);
		chk(21'({clock_path.use_multiplier, clock_path.mult_power_down,
			lock_status, cross_point_en, loop_tuning}), 21'h4E7);
		rd(8'h17, 8'h05);
		close_out();
	end
endmodule : dac_clock_multiplier_control_test
